// ### design/rtc_alarm_pkg.sv
// Package: register map, field positions, reset values and timing for alarm/control logic
package rtc_alarm_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_SEC       = 8'h00;
   localparam logic [7:0] ADDR_A1_SEC    = 8'h07;
   localparam logic [7:0] ADDR_A1_MIN    = 8'h08;
   localparam logic [7:0] ADDR_A1_HOUR   = 8'h09;
   localparam logic [7:0] ADDR_A1_DAY    = 8'h0A;
   localparam logic [7:0] ADDR_A2_MIN    = 8'h0B;
   localparam logic [7:0] ADDR_A2_HOUR   = 8'h0C;
   localparam logic [7:0] ADDR_A2_DAY    = 8'h0D;
   localparam logic [7:0] ADDR_CONTROL   = 8'h0E;
   localparam logic [7:0] ADDR_STATUS    = 8'h0F;
   localparam logic [7:0] ADDR_TRICKLE   = 8'h10;
   // Field positions
   localparam int MASK_BIT      = 7;
   localparam int DAYSEL_BIT    = 6;
   localparam int OSC_STOP_BIT  = 7;
   localparam int BACKUP_EN_BIT = 5;
   localparam int RATE_HI_BIT   = 4;
   localparam int RATE_LO_BIT   = 3;
   localparam int IRQ_MODE_BIT  = 2;
   localparam int A2_EN_BIT     = 1;
   localparam int A1_EN_BIT     = 0;
   localparam int OSF_BIT       = 7;
   localparam int A2_FLAG_BIT   = 1;
   localparam int A1_FLAG_BIT   = 0;
   // Writable masks and reset values
   localparam logic [7:0] CONTROL_WMASK = 8'hBF;
   localparam logic [7:0] CONTROL_RESET = 8'h18;
   localparam logic [7:0] TRICKLE_RESET = 8'h00;
   localparam logic [7:0] ALARM_RESET   = 8'h00;
   localparam logic [3:0] CHARGER_KEY   = 4'hA;
   localparam logic [5:0] DAYDATE_MASK  = 6'h3F;
   // Oscillator and square-wave timing
   localparam int OSC_HZ   = 32768;
   localparam int DIV_1HZ  = OSC_HZ / 2;
   localparam int DIV_4K   = OSC_HZ / 4096 / 2;
   localparam int DIV_8K   = OSC_HZ / 8192 / 2;

   // Timekeeping snapshot compared against the alarms
   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] day;
      logic [7:0] date;
   } time_s;

   // Decoded trickle charger configuration
   typedef struct packed {
      logic       enable;
      logic       diode;
      logic [1:0] resistor;
   } charger_s;

   typedef enum logic [1:0] {
      RATE_1HZ  = 2'b00,
      RATE_4K   = 2'b01,
      RATE_8K   = 2'b10,
      RATE_32K  = 2'b11
   } rate_e;
endpackage

// ### design/rtc_alarm_control_status.sv
// Alarm matching, control, status and trickle configuration for a serial clock
`timescale 1ns/1ps

module rtc_alarm_control_status (
   input  wire logic                    mclk,
   input  wire logic                    rst,
   input  wire logic                    oscTick,
   input  wire logic                    oscStopped,
   input  wire logic                    secondTick,
   input  wire rtc_alarm_pkg::time_s    timeNow,
   input  wire logic                    onBackup,
   input  wire logic                    regWrite,
   input  wire logic [7:0]              regAddr,
   input  wire logic [7:0]              regWdata,
   output logic      [7:0]              regRdata,
   output logic                         waveOrIrqOut,
   output logic                         waveOrIrqOutOe,
   output logic                         oscRun,
   output rtc_alarm_pkg::charger_s      charger
);

   // ************************************************************
   // Register storage
   // ************************************************************
   logic [7:0] alarmOne [4];
   logic [7:0] alarmTwo [3];
   logic [7:0] control;
   logic [7:0] trickle;
   logic       alarmOneFlag;
   logic       alarmTwoFlag;
   logic       oscHaltedFlag;
   logic       oscStoppedQ;
   logic       matchOne;
   logic       matchTwo;
   logic       squareWave;
   logic [13:0] divCount;
   logic        sqRun;

   // Field compare: masked fields always match
   function automatic logic fieldHit(input logic [7:0] alarm, input logic [7:0] now);
      fieldHit = alarm[rtc_alarm_pkg::MASK_BIT] || (alarm[6:0] == now[6:0]);
   endfunction

   // Day/date compare picks weekday or month day from the selector bit
   function automatic logic dayHit(input logic [7:0] alarm, input rtc_alarm_pkg::time_s t);
      logic [7:0] ref8;
      ref8 = alarm[rtc_alarm_pkg::DAYSEL_BIT] ? t.day : t.date;
      dayHit = alarm[rtc_alarm_pkg::MASK_BIT] ||
               ((alarm[5:0] & rtc_alarm_pkg::DAYDATE_MASK) == ref8[5:0]);
   endfunction

   // ************************************************************
   // Alarm matching
   // ************************************************************
   // Each field masked independently; unlisted mask mixes simply AND the
   // unmasked fields, which is consistent and cheap.
   always_comb begin
      matchOne = fieldHit(alarmOne[0], timeNow.sec) &&
                 fieldHit(alarmOne[1], timeNow.min) &&
                 fieldHit(alarmOne[2], timeNow.hour) &&
                 dayHit(alarmOne[3], timeNow);
      // Alarm two has no seconds field: it can only fire at second 00
      matchTwo = (timeNow.sec == 8'h00) &&
                 fieldHit(alarmTwo[0], timeNow.min) &&
                 fieldHit(alarmTwo[1], timeNow.hour) &&
                 dayHit(alarmTwo[2], timeNow);
   end

   // Alarm registers written directly by software
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) alarmOne[i] <= rtc_alarm_pkg::ALARM_RESET;
         for (int i = 0; i < 3; i++) alarmTwo[i] <= rtc_alarm_pkg::ALARM_RESET;
      end else if (regWrite) begin
         case (regAddr)
            rtc_alarm_pkg::ADDR_A1_SEC:  alarmOne[0] <= regWdata;
            rtc_alarm_pkg::ADDR_A1_MIN:  alarmOne[1] <= regWdata;
            rtc_alarm_pkg::ADDR_A1_HOUR: alarmOne[2] <= regWdata;
            rtc_alarm_pkg::ADDR_A1_DAY:  alarmOne[3] <= regWdata;
            rtc_alarm_pkg::ADDR_A2_MIN:  alarmTwo[0] <= regWdata;
            rtc_alarm_pkg::ADDR_A2_HOUR: alarmTwo[1] <= regWdata;
            rtc_alarm_pkg::ADDR_A2_DAY:  alarmTwo[2] <= regWdata;
            default: ;
         endcase
      end
   end

   // ************************************************************
   // Control and trickle registers
   // ************************************************************
   // Reserved control bit 6 is never stored, so it reads zero
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         control <= rtc_alarm_pkg::CONTROL_RESET;
         trickle <= rtc_alarm_pkg::TRICKLE_RESET;
      end else if (regWrite) begin
         if (regAddr == rtc_alarm_pkg::ADDR_CONTROL)
            control <= regWdata & rtc_alarm_pkg::CONTROL_WMASK;
         if (regAddr == rtc_alarm_pkg::ADDR_TRICKLE)
            trickle <= regWdata;
      end
   end

   // Charger decode: key, diode and resistor must all be legal
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         charger <= '0;
      end else begin
         charger.enable   <= (trickle[7:4] == rtc_alarm_pkg::CHARGER_KEY) &&
                             (trickle[3:2] == 2'b01 || trickle[3:2] == 2'b10) &&
                             (trickle[1:0] != 2'b00);
         charger.diode    <= (trickle[3:2] == 2'b10);
         charger.resistor <= trickle[1:0];
      end
   end

   // ************************************************************
   // Status flags
   // ************************************************************
   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         alarmOneFlag <= 1'b0;
         alarmTwoFlag <= 1'b0;
      end else begin
         if (secondTick && matchOne)
            alarmOneFlag <= 1'b1;
         else if (regWrite && regAddr == rtc_alarm_pkg::ADDR_STATUS &&
                  !regWdata[rtc_alarm_pkg::A1_FLAG_BIT])
            alarmOneFlag <= 1'b0;
         if (secondTick && matchTwo)
            alarmTwoFlag <= 1'b1;
         else if (regWrite && regAddr == rtc_alarm_pkg::ADDR_STATUS &&
                  !regWdata[rtc_alarm_pkg::A2_FLAG_BIT])
            alarmTwoFlag <= 1'b0;
      end
   end

   // Stop flag starts set: reset stands for first power-up
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         oscStoppedQ   <= 1'b1;
         oscHaltedFlag <= 1'b1;
      end else begin
         oscStoppedQ <= oscStopped || control[rtc_alarm_pkg::OSC_STOP_BIT];
         if ((oscStopped || control[rtc_alarm_pkg::OSC_STOP_BIT]) && !oscStoppedQ)
            oscHaltedFlag <= 1'b1;
         else if (regWrite && regAddr == rtc_alarm_pkg::ADDR_STATUS &&
                  !regWdata[rtc_alarm_pkg::OSF_BIT])
            oscHaltedFlag <= 1'b0;
      end
   end

   // ************************************************************
   // Square wave and shared output
   // ************************************************************
   // Divider runs on oscillator ticks; 32 kHz mode follows the tick itself
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         divCount   <= '0;
         squareWave <= 1'b0;
         sqRun      <= 1'b0;
      end else begin
         sqRun <= 1'b1;
         if (control[rtc_alarm_pkg::RATE_HI_BIT:rtc_alarm_pkg::RATE_LO_BIT] ==
             rtc_alarm_pkg::RATE_32K) begin
            squareWave <= oscTick;
            divCount   <= '0;
         end else if (oscTick) begin
            if (divCount >= 14'(rateDiv(rtc_alarm_pkg::rate_e'(control[4:3])) - 1)) begin
               divCount   <= '0;
               squareWave <= ~squareWave;
            end else begin
               divCount <= divCount + 14'h0001;
            end
         end
      end
   end

   function automatic int rateDiv(input rtc_alarm_pkg::rate_e r);
      case (r)
         rtc_alarm_pkg::RATE_1HZ: rateDiv = rtc_alarm_pkg::DIV_1HZ;
         rtc_alarm_pkg::RATE_4K:  rateDiv = rtc_alarm_pkg::DIV_4K;
         rtc_alarm_pkg::RATE_8K:  rateDiv = rtc_alarm_pkg::DIV_8K;
         default:                 rateDiv = 1;
      endcase
   endfunction

   // Open-drain pin: low output enable means driving low (interrupt active, or square wave low)
   always_comb begin
      logic pinLow;
      logic irqAct;
      pinLow = 1'b0;
      irqAct = (alarmOneFlag && control[rtc_alarm_pkg::A1_EN_BIT]) ||
               (alarmTwoFlag && control[rtc_alarm_pkg::A2_EN_BIT]);
      if (control[rtc_alarm_pkg::IRQ_MODE_BIT])
         pinLow = irqAct;
      else
         pinLow = sqRun && !squareWave;
      // Without backup enable the pin floats once main supply is gone
      if (onBackup && !control[rtc_alarm_pkg::BACKUP_EN_BIT])
         pinLow = 1'b0;
      waveOrIrqOut   = 1'b0;
      waveOrIrqOutOe = ~pinLow;
   end

   assign oscRun = ~control[rtc_alarm_pkg::OSC_STOP_BIT];

   // ************************************************************
   // Read mux
   // ************************************************************
   always_comb begin
      case (regAddr)
         rtc_alarm_pkg::ADDR_A1_SEC:  regRdata = alarmOne[0];
         rtc_alarm_pkg::ADDR_A1_MIN:  regRdata = alarmOne[1];
         rtc_alarm_pkg::ADDR_A1_HOUR: regRdata = alarmOne[2];
         rtc_alarm_pkg::ADDR_A1_DAY:  regRdata = alarmOne[3];
         rtc_alarm_pkg::ADDR_A2_MIN:  regRdata = alarmTwo[0];
         rtc_alarm_pkg::ADDR_A2_HOUR: regRdata = alarmTwo[1];
         rtc_alarm_pkg::ADDR_A2_DAY:  regRdata = alarmTwo[2];
         rtc_alarm_pkg::ADDR_CONTROL: regRdata = control;
         rtc_alarm_pkg::ADDR_STATUS:
            regRdata = {oscHaltedFlag, 5'b00000, alarmTwoFlag, alarmOneFlag};
         rtc_alarm_pkg::ADDR_TRICKLE: regRdata = trickle;
         default:                     regRdata = 8'h00;
      endcase
   end

endmodule

// ### dv/reg_host_model.sv
// Register host model that drives single-byte writes and reads into the block
`timescale 1ns/1ps
module reg_host_model (
   input  wire logic       mclk,
   input  wire logic [7:0] regRdata,
   output logic            regWrite,
   output logic [7:0]      regAddr,
   output logic [7:0]      regWdata
);
   // Park on an unmapped address so the idle bus reads no live register until the first access
   initial begin
      regWrite = 1'b0;
      regAddr  = 8'h11;
      regWdata = 8'h00;
   end
   // Strobe is launched after one edge and taken at the next; data is inverted afterwards
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1 regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(posedge mclk);
      #1 regWrite = 1'b0;
      regWdata = ~d;
   endtask
   // Read data is combinational, so it is taken at the edge after the address settles
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      #1 regAddr = a;
      @(posedge mclk);
      d = regRdata;
      #1;
   endtask
endmodule

// ### dv/rtc_alarm_assertions.sv
// Port-level checker for the alarm, control and status block
`timescale 1ns/1ps
module rtc_alarm_checker (
   input wire logic                    mclk,
   input wire logic                    rst,
   input wire logic                    oscStopped,
   input wire logic                    onBackup,
   input wire logic                    regWrite,
   input wire logic [7:0]              regAddr,
   input wire logic [7:0]              regWdata,
   input wire logic [7:0]              regRdata,
   input wire logic                    waveOrIrqOutOe,
   input wire logic                    oscRun,
   input wire rtc_alarm_pkg::charger_s charger
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // Status addressed with no write across two edges
   sequence s_stat_idle;
      regAddr == 8'h0F && !regWrite ##1 regAddr == 8'h0F && !regWrite;
   endsequence
   sequence s_stop_seen;
      $rose(oscStopped) ##1 (regAddr == 8'h0F && !regWrite) [*2];
   endsequence
   sequence s_trickle_wr;
      regWrite && regAddr == 8'h10;
   endsequence
   a_ctrl_unused: assert property (regAddr == 8'h0E |-> !regRdata[6])
      else $error("control bit 6 reads one");
   a_stat_unused: assert property (regAddr == 8'h0F |-> regRdata[6:2] == 5'h00)
      else $error("status bits 6 to 2 not zero");
   a_osc_run: assert property (regAddr == 8'h0E |-> oscRun == !regRdata[7])
      else $error("oscillator run disagrees with control");
   a_flag_hold: assert property (s_stat_idle |->
      ((regRdata & $past(regRdata)) & 8'h83) == ($past(regRdata) & 8'h83))
      else $error("status flag dropped without a write");
   a_stop_flag: assert property (s_stop_seen |-> regRdata[7])
      else $error("oscillator stop not flagged");
   // Charger decode sits one register behind the stored byte: look two edges on
   a_key_gate: assert property (s_trickle_wr |-> ##2 charger.enable ==
      ($past(regWdata[7:4], 2) == 4'hA && ^$past(regWdata[3:2], 2) &&
       $past(regWdata[1:0], 2) != 2'b00))
      else $error("charger enable wrong");
   a_charger_field: assert property (s_trickle_wr |-> ##2 !charger.enable ||
      (charger.diode == $past(regWdata[3], 2) &&
       charger.resistor == $past(regWdata[1:0], 2)))
      else $error("charger diode or resistor wrong");
   a_backup_float: assert property (
      (regAddr == 8'h0E && !regRdata[5] && onBackup) [*2] |-> waveOrIrqOutOe)
      else $error("pin driven on backup supply");
   a_irq_gate: assert property (
      (regAddr == 8'h0E && regRdata[2:0] == 3'b100) [*2] |-> waveOrIrqOutOe)
      else $error("pin driven with both alarm enables off");
endmodule
bind rtc_alarm_control_status rtc_alarm_checker i_chk (.mclk(mclk), .rst(rst),
   .oscStopped(oscStopped), .onBackup(onBackup), .regWrite(regWrite), .regAddr(regAddr),
   .regWdata(regWdata), .regRdata(regRdata), .waveOrIrqOutOe(waveOrIrqOutOe),
   .oscRun(oscRun), .charger(charger));

// ### dv/test_rtc_alarm_control_status.sv
// Self-checking testbench for the alarm, control and status block
`timescale 1ns/1ps
module test_rtc_alarm_control_status;
   logic mclk = 1'b0, rst = 1'b1, oscTick = 1'b0, oscStopped = 1'b0;
   logic secondTick = 1'b0, onBackup = 1'b0, regWrite, waveOrIrqOut, waveOrIrqOutOe, oscRun;
   logic [7:0] regAddr, regWdata, regRdata, rd;
   logic [7:0] ctl [6] = '{8'h05, 8'h06, 8'h04, 8'h25, 8'h05, 8'h07};
   logic [7:0] cv [6] = '{8'hA5, 8'hAB, 8'hAE, 8'hA4, 8'h57, 8'hA6};
   logic [0:5] bk = 6'b000110, expOe = 6'b011011;
   logic en, prev;
   rtc_alarm_pkg::charger_s charger;
   rtc_alarm_pkg::time_s timeNow = '0, base = 40'h30_1509_0321;
   int miscompares = 0, n_checks = 0, edges, e;
   always #20 mclk = ~mclk;
   // Oscillator ticks every 8 cycles, far faster than real time, to keep runs short
   always begin
      repeat (7) @(posedge mclk);
      #1 oscTick = 1'b1;
      @(posedge mclk);
      #1 oscTick = 1'b0;
   end
   reg_host_model i_host (.mclk(mclk), .regRdata(regRdata), .regWrite(regWrite),
      .regAddr(regAddr), .regWdata(regWdata));
   rtc_alarm_control_status i_dut (.mclk(mclk), .rst(rst), .oscTick(oscTick),
      .oscStopped(oscStopped), .secondTick(secondTick), .timeNow(timeNow),
      .onBackup(onBackup), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
      .regRdata(regRdata), .waveOrIrqOut(waveOrIrqOut), .waveOrIrqOutOe(waveOrIrqOutOe),
      .oscRun(oscRun), .charger(charger));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] x);
      i_host.rd(a, rd);
      check($sformatf("reg %h", a), rd, x);
   endtask
   task automatic summarize();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // One second strobe carrying the given time
   task automatic tick(input rtc_alarm_pkg::time_s tt);
      @(posedge mclk);
      #1 timeNow = tt;
      secondTick = 1'b1;
      @(posedge mclk);
      #1 secondTick = 1'b0;
   endtask
   function automatic rtc_alarm_pkg::time_s bump(input rtc_alarm_pkg::time_s b, input int f);
      if (f == 0) b.sec = b.sec ^ 8'h01;
      if (f == 1) b.min = b.min ^ 8'h01;
      if (f == 2) b.hour = b.hour ^ 8'h01;
      if (f == 3) b.date = b.date ^ 8'h01;
      return b;
   endfunction
   // Each mask pattern: a tick off only in masked fields fires, one off in a compared field not
   task automatic alarm_walk(input int two);
      logic [7:0] vals [4] = '{8'h30, 8'h15, 8'h09, 8'h21};
      logic [7:0] flag;
      rtc_alarm_pkg::time_s t;
      flag = two ? 8'h02 : 8'h01;
      for (int u = 0; u <= 4 - two; u++) begin
         for (int k = two; k < 4; k++) i_host.wr(8'h07 + 8'(3 * two + k), {k >= u + two, vals[k][6:0]});
         t = base;
         if (two) t.sec = 8'h00;
         tick(bump(t, u + two));
         rdc(8'h0F, flag);
         i_host.wr(8'h0F, 8'h00);
         tick(bump(t, u == 0 ? 0 : u - 1 + two));
         rdc(8'h0F, (u == 0 && two == 0) ? flag : 8'h00);
         i_host.wr(8'h0F, 8'h00);
      end
   endtask
   // Hang guard, several times the expected run length
   initial begin
      #800_000;
      miscompares++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge mclk);
      #1 rst = 1'b0;
      rdc(8'h0E, 8'h18);
      rdc(8'h0F, 8'h80);
      rdc(8'h10, 8'h00);
      rdc(8'h11, 8'h00);
      for (int a = 7; a < 14; a++) rdc(8'(a), 8'h00);
      i_host.wr(8'h0E, 8'hFF);
      rdc(8'h0E, 8'hBF);
      // Ones to the stop flag and reserved bits change nothing; a zero clears
      i_host.wr(8'h0F, 8'hFC);
      rdc(8'h0F, 8'h80);
      i_host.wr(8'h0F, 8'h7C);
      rdc(8'h0F, 8'h00);
      i_host.wr(8'h0E, 8'h00);
      $display("test reset done");
      alarm_walk(0);
      alarm_walk(1);
      i_host.wr(8'h0A, 8'h03);
      tick(base);
      rdc(8'h0F, 8'h00);
      i_host.wr(8'h0A, 8'h43);
      tick(base);
      rdc(8'h0F, 8'h01);
      $display("test alarms done");
      for (int i = 0; i < 6; i++) begin
         onBackup = bk[i];
         i_host.wr(8'h0F, i == 5 ? 8'h00 : 8'h03);
         i_host.wr(8'h0E, ctl[i]);
         repeat (2) @(posedge mclk);
         #1 check("pin oe", {7'h00, waveOrIrqOutOe}, {7'h00, expOe[i]});
         check("pin data", {7'h00, waveOrIrqOut}, 8'h00);
      end
      onBackup = 1'b0;
      $display("test interrupt done");
      for (int r = 1; r < 4; r++) begin
         i_host.wr(8'h0E, 8'(r << 3));
         repeat (40) @(posedge mclk);
         // Fastest rate follows every oscillator tick: two pin edges per tick
         e = (r == 3) ? 128 :
             64 / (r == 1 ? rtc_alarm_pkg::DIV_4K : rtc_alarm_pkg::DIV_8K);
         edges = 0;
         prev = waveOrIrqOutOe;
         repeat (512) begin
            @(negedge mclk);
            edges += int'(waveOrIrqOutOe !== prev);
            prev = waveOrIrqOutOe;
         end
         check("wave edges", {7'h00, edges >= e - 1 && edges <= e + 1}, 8'h01);
      end
      $display("test square wave done");
      i_host.wr(8'h0E, 8'h80);
      check("oscRun", {7'h00, oscRun}, 8'h00);
      rdc(8'h0F, 8'h80);
      i_host.wr(8'h0E, 8'h00);
      i_host.wr(8'h0F, 8'h00);
      rdc(8'h0F, 8'h00);
      oscStopped = 1'b1;
      repeat (4) @(posedge mclk);
      #1 oscStopped = 1'b0;
      rdc(8'h0F, 8'h80);
      $display("test oscillator stop done");
      foreach (cv[i]) begin
         i_host.wr(8'h10, cv[i]);
         // Charger decode is registered behind the stored byte: wait one more edge
         @(posedge mclk);
         #1 en = cv[i][7:4] == 4'hA && ^cv[i][3:2] && cv[i][1:0] != 2'b00;
         check("charger on", {7'h00, charger.enable}, {7'h00, en});
         if (en) check("charger", {4'h0, charger}, {4'h0, en, cv[i][3], cv[i][1:0]});
         rdc(8'h10, cv[i]);
      end
      $display("test charger done");
      summarize();
   end
endmodule
